// >>> src/plmc_params.svh
/*
 * Constants of the LED and crossover control block: register indices, field positions,
 * reset values and timing figures.
 * Assumes it is included by bare name from the package and the top module.
 */
`ifndef PLMC_PARAMS_SVH
`define PLMC_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define PLMC_IDX_LED_OVERRIDE_CONTROL 8'h18
`define PLMC_IDX_PHY_GENERAL_CONTROL  8'h19

// LED override control fields
`define PLMC_LED_RATE_HI     10
`define PLMC_LED_RATE_LO     9
`define PLMC_LED_POL_SPEED   8
`define PLMC_LED_POL_LINK    7
`define PLMC_LED_POL_ACT     6
`define PLMC_LED_DRV_SPEED   5
`define PLMC_LED_DRV_LINK    4
`define PLMC_LED_DRV_ACT     3
`define PLMC_LED_VAL_SPEED   2
`define PLMC_LED_VAL_LINK    1
`define PLMC_LED_VAL_ACT     0
`define PLMC_LED_RESET       11'h400

// PHY general control fields
`define PLMC_PHY_AUTO_MDIX   15
`define PLMC_PHY_FORCE_MDIX  14
`define PLMC_PHY_PAUSE_RX    13
`define PLMC_PHY_PAUSE_TX    12

// Timing: clock period and blink phase lengths
`define PLMC_CLK_PERIOD_NS   50
`define PLMC_NS_PER_MS       1000000
`define PLMC_PHASE_MS_20HZ   10'h032
`define PLMC_PHASE_MS_10HZ   10'h064
`define PLMC_PHASE_MS_5HZ    10'h0C8
`define PLMC_PHASE_MS_2HZ    10'h1F4

`endif

// >>> src/plmc_pkg.sv
/*
 * Types of the LED and crossover control block.
 * Assumes plmc_params.svh is on the include path.
 */
package plmc_pkg;
    `include "plmc_params.svh"

    // Blink rate codes of the two-bit field
    typedef enum logic [1:0] {
        PLMC_RATE_20HZ = 2'h0,
        PLMC_RATE_10HZ = 2'h1,
        PLMC_RATE_5HZ  = 2'h2,
        PLMC_RATE_2HZ  = 2'h3
    } plmc_rate_t;

    // Strap capture sequence after reset release
    typedef enum logic [3:0] {
        PLMC_ST_SYNC1 = 4'h1,
        PLMC_ST_SYNC2 = 4'h2,
        PLMC_ST_LOAD  = 4'h4,
        PLMC_ST_DONE  = 4'h8
    } plmc_strap_t;
endpackage

// >>> src/plmc_top.sv
/*
 * LED override and crossover control register bank behind an APB slave.
 * Drives the three status LEDs with polarity and force, blinks the activity LED, holds the crossover
 * controls and reports resolved pause flags.
 * Assumes status and advertisement inputs come from logic on pclk; straps are pins.
 */
// The APB interface to the registers was decided locally.
// Overview of operation
// - Reserved LED bits read zero, ignore writes
// - Blink field picks phase length, resets 10
// - Speed polarity from strap, software may override
// - Link polarity from strap, software may override
// - Activity polarity from strap, software may override
// - Speed override drives speed force value
// - Link override drives link force value
// - Activity override drives activity force value
// - Auto crossover enable from strap, default one
// - Forced crossover swaps transmit and receive pairs
// - Pause receive resolved, full duplex only
// - Pause transmit resolved, full duplex only
`timescale 1ns/10ps
`include "plmc_params.svh"

module plmc_top
    import plmc_pkg::*;
#(
    parameter int TICK_CYCLES = `PLMC_NS_PER_MS / `PLMC_CLK_PERIOD_NS  // Clocks per millisecond
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Strap pins, asynchronous
    input  wire logic        strap_speed_pol,
    input  wire logic        strap_link_pol,
    input  wire logic        strap_act_pol,
    input  wire logic        strap_auto_mdix,
    // Normal indication from the PHY core
    input  wire logic        speed_status,
    input  wire logic        link_status,
    input  wire logic        activity_status,
    // Pause advertisement bits 11:10 and negotiated duplex
    input  wire logic [1:0]  local_advert_reg,
    input  wire logic [1:0]  partner_ability_reg,
    input  wire logic        an_full_duplex,
    // LED pins
    output logic             speed_indicator_out,
    output logic             link_indicator_out,
    output logic             activity_indicator_out,
    // Crossover controls to the pair switch
    output logic             auto_mdix_enable,
    output logic             force_crossover
);

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam logic [7:0] ADDR_LED = 8'(`PLMC_IDX_LED_OVERRIDE_CONTROL * 4);
    localparam logic [7:0] ADDR_PHY = 8'(`PLMC_IDX_PHY_GENERAL_CONTROL * 4);

    logic [10:0]       led_ctrl_ff;       // Writable LED control bits 10:0
    logic [1:0]        mdix_ctrl_ff;      // Auto and forced crossover bits
    logic [3:0]        strap_meta_ff;     // First synchroniser stage
    logic [3:0]        strap_sync_ff;     // Second synchroniser stage
    plmc_strap_t       strap_st_ff;       // Strap capture sequence
    logic [TICK_W-1:0] tick_cnt_ff;       // Millisecond prescaler
    logic              ms_tick;           // One-cycle enable each millisecond
    logic [9:0]        phase_cnt_ff;      // Milliseconds left in blink phase
    logic [9:0]        phase_len;         // Phase length for the current rate
    logic [1:0]        rate_prev_ff;      // Rate seen last cycle
    logic              rate_changed;      // Rate field moved
    logic              blink_ff;          // Blink phase, high is on
    logic              pause_rx;          // Resolved pause receive
    logic              pause_tx;          // Resolved pause transmit
    logic [31:0]       prdata_ff;         // Registered read data
    logic [31:0]       nxt_prdata;        // Read data for the addressed word
    logic              wr_led;            // Write strobe, LED word
    logic              wr_phy;            // Write strobe, PHY word
    logic              mapped;            // Address hits a register
    logic [2:0]        nxt_led;           // Logical LED states: speed, link, act
    logic [2:0]        led_pin_ff;        // Registered LED pins
    logic [2:0]        pol;               // Polarity per LED

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_led  = psel && penable && pwrite && (paddr == ADDR_LED);
    assign wr_phy  = psel && penable && pwrite && (paddr == ADDR_PHY);
    assign prdata  = prdata_ff;

    // Two-flop synchroniser for the strap pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_meta_ff <= 4'h0;
            strap_sync_ff <= 4'h0;
        end
        else
        begin
            strap_meta_ff <= {strap_auto_mdix, strap_speed_pol, strap_link_pol, strap_act_pol};
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // Straps are caught only once the synchroniser has filled after release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_st_ff <= PLMC_ST_SYNC1;
        end
        else
        begin
            case (strap_st_ff)
                PLMC_ST_SYNC1: strap_st_ff <= PLMC_ST_SYNC2;
                PLMC_ST_SYNC2: strap_st_ff <= PLMC_ST_LOAD;
                default:       strap_st_ff <= PLMC_ST_DONE;
            endcase
        end
    end

    // LED control word; bits 15:11 are not stored so writes vanish
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_ctrl_ff <= `PLMC_LED_RESET;
        end
        else if (wr_led)
        begin
            led_ctrl_ff <= pwdata[10:0];
        end
        else if (strap_st_ff == PLMC_ST_LOAD)
        begin
            // Strap load; a write in the same cycle wins as the newer intent
            led_ctrl_ff[`PLMC_LED_POL_SPEED] <= strap_sync_ff[2];
            led_ctrl_ff[`PLMC_LED_POL_LINK]  <= strap_sync_ff[1];
            led_ctrl_ff[`PLMC_LED_POL_ACT]   <= strap_sync_ff[0];
        end
    end

    // Crossover controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mdix_ctrl_ff <= 2'h2;
        end
        else if (wr_phy)
        begin
            mdix_ctrl_ff <= pwdata[`PLMC_PHY_AUTO_MDIX:`PLMC_PHY_FORCE_MDIX];
        end
        else if (strap_st_ff == PLMC_ST_LOAD)
        begin
            mdix_ctrl_ff[1] <= strap_sync_ff[3];
        end
    end
    assign auto_mdix_enable = mdix_ctrl_ff[1];
    assign force_crossover  = mdix_ctrl_ff[0];

    // Pause resolution: symmetric when both pause, else asymmetric pairs
    always_comb
    begin
        pause_rx = 1'b0;
        pause_tx = 1'b0;
        if (an_full_duplex)
        begin
            if (local_advert_reg[0] && partner_ability_reg[0])
            begin
                pause_rx = 1'b1;
                pause_tx = 1'b1;
            end
            else if (local_advert_reg == 2'h3 && partner_ability_reg == 2'h2)
            begin
                pause_rx = 1'b1;
            end
            else if (local_advert_reg == 2'h2 && partner_ability_reg == 2'h3)
            begin
                pause_tx = 1'b1;
            end
        end
    end

    // Read mux and address decode; reserved and out-of-scope bits read zero
    always_comb
    begin
        nxt_prdata = 32'h0;
        mapped     = 1'b0;
        if (paddr == ADDR_LED)
        begin
            mapped           = 1'b1;
            nxt_prdata[10:0] = led_ctrl_ff;
        end
        else if (paddr == ADDR_PHY)
        begin
            mapped            = 1'b1;
            nxt_prdata[15:12] = {mdix_ctrl_ff, pause_rx, pause_tx};
        end
    end

    // Read data latched in the setup cycle, stable through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Millisecond prescaler keeps the phase counters narrow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_ff <= '0;
        end
        else
        begin
            tick_cnt_ff <= ms_tick ? '0 : tick_cnt_ff + 1'b1;
        end
    end
    assign ms_tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));

    // Phase length per rate code
    always_comb
    begin
        case (plmc_rate_t'(led_ctrl_ff[`PLMC_LED_RATE_HI:`PLMC_LED_RATE_LO]))
            PLMC_RATE_20HZ: phase_len = `PLMC_PHASE_MS_20HZ;
            PLMC_RATE_10HZ: phase_len = `PLMC_PHASE_MS_10HZ;
            PLMC_RATE_5HZ:  phase_len = `PLMC_PHASE_MS_5HZ;
            default:        phase_len = `PLMC_PHASE_MS_2HZ;
        endcase
    end
    assign rate_changed = (rate_prev_ff != led_ctrl_ff[`PLMC_LED_RATE_HI:`PLMC_LED_RATE_LO]);

    // Blink phase counter; a new rate restarts the phase at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rate_prev_ff <= 2'h2;
            phase_cnt_ff <= `PLMC_PHASE_MS_5HZ;
            blink_ff     <= 1'b1;
        end
        else
        begin
            rate_prev_ff <= led_ctrl_ff[`PLMC_LED_RATE_HI:`PLMC_LED_RATE_LO];
            if (rate_changed)
            begin
                phase_cnt_ff <= phase_len;
                blink_ff     <= 1'b1;
            end
            else if (ms_tick && phase_cnt_ff == 10'h001)
            begin
                phase_cnt_ff <= phase_len;
                blink_ff     <= !blink_ff;
            end
            else if (ms_tick)
            begin
                phase_cnt_ff <= phase_cnt_ff - 10'h001;
            end
        end
    end

    // Logical LED state: force value wins, else normal; activity blinks
    always_comb
    begin
        nxt_led[2] = led_ctrl_ff[`PLMC_LED_DRV_SPEED] ? led_ctrl_ff[`PLMC_LED_VAL_SPEED] : speed_status;
        nxt_led[1] = led_ctrl_ff[`PLMC_LED_DRV_LINK] ? led_ctrl_ff[`PLMC_LED_VAL_LINK] : link_status;
        nxt_led[0] = led_ctrl_ff[`PLMC_LED_DRV_ACT] ? led_ctrl_ff[`PLMC_LED_VAL_ACT]
                                                     : (activity_status && blink_ff);
    end
    assign pol = led_ctrl_ff[`PLMC_LED_POL_SPEED:`PLMC_LED_POL_ACT];

    // Pins registered so no decode glitch reaches an LED; low polarity inverts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_pin_ff <= 3'h7;
        end
        else
        begin
            led_pin_ff <= ~(nxt_led ^ pol);
        end
    end
    assign speed_indicator_out    = led_pin_ff[2];
    assign link_indicator_out     = led_pin_ff[1];
    assign activity_indicator_out = led_pin_ff[0];

    // Checks beside the logic they guard
    a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == ADDR_LED) |=> prdata[31:11] == 21'h0)
        else $error("reserved LED bits not zero");
    a_rate_reload: assert property (@(posedge pclk) disable iff (!presetn)
        wr_led && (pwdata[10:9] != led_ctrl_ff[10:9]) |-> ##2 phase_cnt_ff == $past(phase_len))
        else $error("blink counter not reloaded on rate change");
    a_speed_pin: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 speed_indicator_out == ($past(pol[2]) ? $past(nxt_led[2]) : !$past(nxt_led[2])))
        else $error("speed pin polarity wrong");
    a_link_pin: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 link_indicator_out == ($past(pol[1]) ? $past(nxt_led[1]) : !$past(nxt_led[1])))
        else $error("link pin polarity wrong");
    a_act_pin: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 activity_indicator_out == ($past(pol[0]) ? $past(nxt_led[0]) : !$past(nxt_led[0])))
        else $error("activity pin polarity wrong");
    a_speed_force: assert property (@(posedge pclk) disable iff (!presetn)
        led_ctrl_ff[5] |=> speed_indicator_out == !($past(led_ctrl_ff[2]) ^ $past(led_ctrl_ff[8])))
        else $error("speed force ignored");
    a_link_force: assert property (@(posedge pclk) disable iff (!presetn)
        led_ctrl_ff[4] |=> link_indicator_out == !($past(led_ctrl_ff[1]) ^ $past(led_ctrl_ff[7])))
        else $error("link force ignored");
    a_act_force: assert property (@(posedge pclk) disable iff (!presetn)
        led_ctrl_ff[3] |=> activity_indicator_out == !($past(led_ctrl_ff[0]) ^ $past(led_ctrl_ff[6])))
        else $error("activity force ignored");
    a_mdix_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_phy |=> auto_mdix_enable == $past(pwdata[15]) && force_crossover == $past(pwdata[14]))
        else $error("crossover write lost");
    a_pause_half: assert property (@(posedge pclk) disable iff (!presetn)
        !an_full_duplex |-> !pause_rx && !pause_tx)
        else $error("pause flag in half duplex");
    a_pause_sym: assert property (@(posedge pclk) disable iff (!presetn)
        an_full_duplex && local_advert_reg[0] && partner_ability_reg[0] |-> pause_rx && pause_tx)
        else $error("symmetric pause not resolved");

endmodule

// >>> test/plmc_core_model.sv
/*
 * Behavioural PHY core beside the LED block: the status and advertisement sources.
 * Assumes the bench sets wanted levels; outputs move only just after pclk rises.
 */
`timescale 1ns/10ps

module plmc_core_model
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Wanted levels from the bench
    input  wire logic [2:0] want_status,
    input  wire logic [1:0] want_local,
    input  wire logic [1:0] want_partner,
    input  wire logic       want_fd,
    // Core outputs towards the block
    output logic            speed_status,
    output logic            link_status,
    output logic            activity_status,
    output logic [1:0]      local_advert_reg,
    output logic [1:0]      partner_ability_reg,
    output logic            an_full_duplex
);
    // Registered like real core logic, so nothing changes in the sampling step
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {speed_status, link_status, activity_status} <= 3'h0;
            local_advert_reg                               <= 2'h0;
            partner_ability_reg                            <= 2'h0;
            an_full_duplex                                 <= 1'b0;
        end
        else
        begin
            {speed_status, link_status, activity_status} <= want_status;
            local_advert_reg                               <= want_local;
            partner_ability_reg                            <= want_partner;
            an_full_duplex                                 <= want_fd;
        end
    end
endmodule

// >>> test/tb_phy_led_and_mdix_control.sv
/*
 * Self-checking bench of the LED and crossover register bank, driven over APB.
 * Assumes the design files under src/ and the core model; blink ticks are shortened.
 */
`timescale 1ns/10ps
`include "plmc_params.svh"

module tb_phy_led_and_mdix_control
    import plmc_pkg::*;
;
    localparam int         TICK  = 4;  // Short millisecond keeps blink checks quick
    localparam logic [7:0] A_LED = 8'(`PLMC_IDX_LED_OVERRIDE_CONTROL * 4);
    localparam logic [7:0] A_PHY = 8'(`PLMC_IDX_PHY_GENERAL_CONTROL * 4);
    localparam logic [7:0] A_BAD = 8'h68;  // Unmapped word
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        strap_speed_pol, strap_link_pol, strap_act_pol, strap_auto_mdix;
    logic        speed_status, link_status, activity_status, an_full_duplex, want_fd;
    logic [1:0]  local_advert_reg, partner_ability_reg, want_local, want_partner;
    logic [2:0]  want_status, pol;
    logic        speed_indicator_out, link_indicator_out, activity_indicator_out;
    logic        auto_mdix_enable, force_crossover;
    int          errors, checks;
    int          ph [4] = '{50, 100, 200, 500};  // Blink phase lengths in ms

    plmc_top #(.TICK_CYCLES(TICK)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_speed_pol(strap_speed_pol), .strap_link_pol(strap_link_pol), .strap_act_pol(strap_act_pol),
        .strap_auto_mdix(strap_auto_mdix), .speed_status(speed_status), .link_status(link_status),
        .activity_status(activity_status), .local_advert_reg(local_advert_reg),
        .partner_ability_reg(partner_ability_reg), .an_full_duplex(an_full_duplex),
        .speed_indicator_out(speed_indicator_out), .link_indicator_out(link_indicator_out),
        .activity_indicator_out(activity_indicator_out), .auto_mdix_enable(auto_mdix_enable),
        .force_crossover(force_crossover));

    plmc_core_model core_u (.pclk(pclk), .presetn(presetn), .want_status(want_status),
        .want_local(want_local), .want_partner(want_partner), .want_fd(want_fd),
        .speed_status(speed_status), .link_status(link_status), .activity_status(activity_status),
        .local_advert_reg(local_advert_reg), .partner_ability_reg(partner_ability_reg),
        .an_full_duplex(an_full_duplex));

    // 20 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Verdict and end of run
    task automatic tally_and_finish();
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Register words
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Single pins and flags
    task automatic chk_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
        begin
            errors++;
            tally_and_finish();
        end
    endtask

    // Let pin updates land, then look at the falling edge
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Pause resolution: {receive, transmit}; bit0 pause, bit1 asymmetric
    function automatic logic [1:0] pause_exp(input logic [1:0] l, input logic [1:0] p, input logic fd);
        if (!fd)
            return 2'h0;
        if (l[0] && p[0])
            return 2'h3;
        if (l == 2'h3 && p == 2'h2)
            return 2'h2;
        if (l == 2'h2 && p == 2'h3)
            return 2'h1;
        return 2'h0;
    endfunction

    // Guard against a hang anywhere
    initial
    begin
        repeat (100000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        errors = 0;
        checks = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {strap_speed_pol, strap_link_pol, strap_act_pol, strap_auto_mdix} = 4'hA;
        {want_status, want_local, want_partner, want_fd} = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, A_LED, 16'h0);
        chk_word(rd, 32'h00000540);
        apb(1'b0, A_PHY, 16'h0);
        chk_word(rd, 32'h00000000);
        chk_pin(auto_mdix_enable, 1'b0);
        apb(1'b1, A_LED, 16'hFFFF);
        apb(1'b0, A_LED, 16'h0);
        chk_word(rd, 32'h000007FF);
        // Unmapped word is refused and leaves the bank alone
        apb(1'b1, A_BAD, 16'h0000);
        apb(1'b0, A_BAD, 16'h0);
        chk_pin(er, 1'b1);
        chk_pin(pready, 1'b1);
        chk_word(rd, 32'h00000000);
        apb(1'b0, A_LED, 16'h0);
        chk_word(rd, 32'h000007FF);
        // Forced values then normal indication, under both polarities
        want_status <= 3'b100;
        for (int p = 0; p < 2; p++)
        begin
            pol = {3{p[0]}};
            apb(1'b1, A_LED, {7'h02, pol, 6'h3D});
            settle(3);
            chk_word({29'h0, speed_indicator_out, link_indicator_out, activity_indicator_out},
                     {29'h0, pol ~^ 3'b101});
            apb(1'b1, A_LED, {7'h02, pol, 6'h00});
            settle(3);
            chk_word({29'h0, speed_indicator_out, link_indicator_out, activity_indicator_out},
                     {29'h0, pol ~^ 3'b100});
        end
        // Every blink rate: on for one phase, then off
        want_status <= 3'b001;
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b1, A_LED, {5'h00, 2'(r), 9'h1C0});
            settle(ph[r] * TICK / 2);
            chk_pin(activity_indicator_out, 1'b1);
            settle(ph[r] * TICK);
            chk_pin(activity_indicator_out, 1'b0);
        end
        // Crossover controls; pause bits are read-only
        apb(1'b1, A_PHY, 16'hF000);
        settle(1);
        chk_pin(auto_mdix_enable, 1'b1);
        chk_pin(force_crossover, 1'b1);
        for (int i = 0; i < 32; i++)
        begin
            want_local   <= i[1:0];
            want_partner <= i[3:2];
            want_fd      <= i[4];
            apb(1'b0, A_PHY, 16'h0);
            chk_word(rd, {16'h0, 2'h3, pause_exp(i[1:0], i[3:2], i[4]), 12'h000});
        end
        apb(1'b1, A_PHY, 16'h4000);
        settle(1);
        chk_pin(auto_mdix_enable, 1'b0);
        chk_pin(force_crossover, 1'b1);
        tally_and_finish();
    end
endmodule
